/* logic/csc_core_ctl.sv */
/*
  main core storage address and read/write half-cycle control.
  assumes the microprogram control raises start pulses on clock phase one,
  and that sense amplifier outputs arrive asynchronously from the array.
*/
`timescale 1ns/10ps
module csc_core_ctl #(
  parameter bit EIGHT_K = 1'b1
) (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               start_fetch,
  input  wire logic               start_store,
  input  wire logic               aux_access,
  input  wire logic               aux_clear,
  input  wire logic               addr_load,
  input  wire logic [3:0]         address_top_nibble_in,
  input  wire logic [3:0]         address_mid_nibble_in,
  input  wire logic [3:0]         internal_bus,
  input  wire logic               address_extension_in,
  input  wire logic               data_load,
  input  wire csc_pkg::csc_byte_t data_in,
  input  wire logic [9:0]         sense_in,
  output csc_pkg::csc_byte_t      data_out,
  output csc_pkg::csc_drive_t     drive,
  output logic [9:0]              inhibit,
  output logic                    sense_strobe,
  output logic                    busy,
  output logic                    parity_error,
  output logic [12:0]             storage_address_register,
  output logic [15:0]             console_hex_address,
  output logic [4:0]              console_extra_display_reg
);
  import csc_pkg::*;

  typedef enum logic [1:0] {CSC_IDLE, CSC_READ, CSC_WRITE} csc_state_t;

  csc_state_t           state_reg, state_next;
  logic [TIMER_W-1:0]   timer_reg, timer_next;
  logic [3:0]           address_top_nibble_reg;
  logic [3:0]           address_mid_nibble_reg;
  logic [3:0]           address_low_nibble_reg;
  logic                 address_extension_latches;
  logic                 aux_latch_reg;
  logic [12:0]          addr_reg;
  csc_half_t            high_half_data_reg;
  csc_half_t            low_half_data_reg;
  logic [9:0]           sense_meta_reg;
  logic [9:0]           sense_sync_reg;
  csc_drive_t           drive_reg;
  logic [9:0]           inhibit_reg;
  logic                 strobe_reg;
  logic                 perr_reg;
  logic [15:0]          hex_reg;
  logic [4:0]           extra_reg;
  logic                 busy_reg;

  // addressing
  wire        ext_bit    = EIGHT_K & address_extension_latches;
  wire [12:0] addr_next  = {ext_bit, address_top_nibble_reg,
                            address_mid_nibble_reg, address_low_nibble_reg}; // RULE_09 RULE_10

  wire        in_read    = (state_reg == CSC_READ);
  wire        in_write   = (state_reg == CSC_WRITE);
  wire        active     = in_read | in_write;
  wire        last_tick  = active && (timer_reg == TIMER_W'(HALF_CYCLE_CYC - 1));
  wire        x_window   = active && (timer_reg >= TIMER_W'(X_ON_START_CYC))
                                  && (timer_reg <  TIMER_W'(DRIVE_END_CYC));
  wire        y_window   = active && (timer_reg >= TIMER_W'(Y_ON_START_CYC))
                                  && (timer_reg <  TIMER_W'(DRIVE_END_CYC));
  wire        inh_window = in_write && (timer_reg < TIMER_W'(INH_END_CYC));
  wire        strb_window = in_read && (timer_reg >= TIMER_W'(STROBE_BEG_CYC))
                                    && (timer_reg <  TIMER_W'(STROBE_END_CYC)); // RULE_20
  // port strobe is set one tick early so the register lands on the window
  wire        strb_early  = in_read && (timer_reg >= TIMER_W'(STROBE_BEG_CYC - 1))
                                    && (timer_reg <  TIMER_W'(STROBE_END_CYC - 1)); // RULE_20

  wire        x_four_en  = x_window & ~aux_latch_reg; // RULE_16

  wire [15:0] y_wr_hot;
  wire [7:0]  y_rd_hot;
  wire [7:0]  x_g1_hot;
  wire [7:0]  x_g2_hot;
  wire [2:0]  x_g2_sel   = {addr_reg[EXT_POS], addr_reg[X_G2_LSB +: 2]}; // RULE_17

  csc_decode #(.IN_W(4)) u_y_wr (
    .en  (y_window),
    .sel (addr_reg[Y_WR_LSB +: 4]),
    .hot (y_wr_hot)
  ); // RULE_11
  csc_decode #(.IN_W(3)) u_y_rd (
    .en  (y_window),
    .sel (addr_reg[Y_RD_LSB +: 3]),
    .hot (y_rd_hot)
  ); // RULE_12
  csc_decode #(.IN_W(3)) u_x_g1 (
    .en  (x_window),
    .sel (addr_reg[X_G1_LSB +: 3]),
    .hot (x_g1_hot)
  ); // RULE_13
  csc_decode #(.IN_W(3)) u_x_g2 (
    .en  (x_four_en),
    .sel (x_g2_sel),
    .hot (x_g2_hot)
  ); // RULE_14 RULE_17

  csc_drive_t drive_next;
  always_comb begin
    drive_next.y_wr_drv  = y_wr_hot;
    drive_next.y_rd_drv  = y_rd_hot;
    drive_next.x_g1      = x_g1_hot;
    drive_next.x_g2      = x_g2_hot;
    drive_next.x_en      = x_window;
    drive_next.y_en      = y_window;
    drive_next.dir_store = in_write; // RULE_15 RULE_06
  end

  // inhibit energized for bits that must stay zero; never during read
  wire csc_byte_t wr_byte   = {high_half_data_reg, low_half_data_reg};
  wire [9:0]      inh_next  = inh_window ? ~wr_byte : 10'h000; // RULE_05 RULE_06 RULE_08

  // parity check on the half-byte registers
  wire hi_perr;
  wire lo_perr;
  csc_parity u_hi_par (
    .data    (high_half_data_reg.data),
    .par_in  (high_half_data_reg.par),
    .par_gen (),
    .par_err (hi_perr)
  ); // RULE_01 RULE_02
  csc_parity u_lo_par (
    .data    (low_half_data_reg.data),
    .par_in  (low_half_data_reg.par),
    .par_gen (),
    .par_err (lo_perr)
  ); // RULE_02

  // loaded data gets fresh parity; the incoming parity field is ignored
  wire hi_load_par;
  wire lo_load_par;
  csc_parity u_hi_gen (
    .data    (data_in.hi.data),
    .par_in  (data_in.hi.par),
    .par_gen (hi_load_par),
    .par_err ()
  ); // RULE_02
  csc_parity u_lo_gen (
    .data    (data_in.lo.data),
    .par_in  (data_in.lo.par),
    .par_gen (lo_load_par),
    .par_err ()
  ); // RULE_02

  // half-cycle sequencer
  wire go_fetch = start_fetch & ~start_store; // RULE_21
  wire go_store = start_store & ~start_fetch;

  always_comb begin
    state_next = state_reg;
    timer_next = active ? timer_reg + TIMER_W'(1) : '0;
    unique case (state_reg)
      CSC_IDLE: begin
        if (go_fetch) begin
          state_next = CSC_READ;
        end else if (go_store) begin
          state_next = CSC_WRITE; // RULE_04
        end
      end
      CSC_READ, CSC_WRITE: begin
        if (last_tick) begin
          state_next = CSC_IDLE; // RULE_03 RULE_04
          timer_next = '0;
        end
      end
    endcase
  end

  wire start_any = (state_reg == CSC_IDLE) & (go_fetch | go_store);
  wire busy_next = (state_next != CSC_IDLE);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_reg <= CSC_IDLE;
      timer_reg <= '0;
      busy_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      busy_reg  <= busy_next;
    end
  end

  // address nibble registers; loading is refused during a half cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      address_top_nibble_reg    <= NIB_RST;
      address_mid_nibble_reg    <= NIB_RST;
      address_low_nibble_reg    <= NIB_RST;
      address_extension_latches <= 1'b0;
    end else if (addr_load && !active) begin
      address_top_nibble_reg    <= address_top_nibble_in;
      address_mid_nibble_reg    <= address_mid_nibble_in;
      address_low_nibble_reg    <= internal_bus; // RULE_10
      address_extension_latches <= address_extension_in;
    end
  end

  // aux latch: set wins over clear
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aux_latch_reg <= 1'b0;
    end else if (aux_access) begin
      aux_latch_reg <= 1'b1; // RULE_22
    end else if (aux_clear) begin
      aux_latch_reg <= 1'b0;
    end
  end

  // storage address register captured at the start of each half cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addr_reg <= ADDR_RST;
    end else if (start_any) begin
      addr_reg <= addr_next; // RULE_09
    end
  end

  // sense inputs come from the array: two-stage synchroniser
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sense_meta_reg <= 10'h000;
      sense_sync_reg <= 10'h000;
    end else begin
      sense_meta_reg <= sense_in;
      sense_sync_reg <= sense_meta_reg;
    end
  end

  // data registers: cleared at read start, sensed ones set latches in window
  wire csc_byte_t sense_byte = sense_sync_reg;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      high_half_data_reg <= HALF_RST;
      low_half_data_reg  <= HALF_RST;
    end else if (start_any && go_fetch) begin
      high_half_data_reg <= '0; // RULE_07
      low_half_data_reg  <= '0;
    end else if (strb_window) begin
      high_half_data_reg <= high_half_data_reg | sense_byte.hi; // RULE_07 RULE_20
      low_half_data_reg  <= low_half_data_reg  | sense_byte.lo;
    end else if (data_load && !active) begin
      high_half_data_reg <= '{par: hi_load_par, data: data_in.hi.data}; // RULE_02 RULE_08
      low_half_data_reg  <= '{par: lo_load_par, data: data_in.lo.data};
    end
  end

  wire perr_set = in_read & last_tick & (hi_perr | lo_perr);

  // registered outputs
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      drive_reg    <= '0;
      inhibit_reg  <= 10'h000;
    end else begin
      drive_reg    <= drive_next;
      inhibit_reg  <= inh_next;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      strobe_reg   <= 1'b0;
    end else begin
      strobe_reg   <= strb_early; // RULE_20
    end
  end

  // error flag cleared by the next start; set and clear never meet in one cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      perr_reg     <= 1'b0;
    end else if (start_any) begin
      perr_reg     <= 1'b0;
    end else if (perr_set) begin
      perr_reg     <= 1'b1; // RULE_02
    end
  end

  // console display of the loaded address
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hex_reg      <= 16'h0000;
      extra_reg    <= 5'h00;
    end else begin
      hex_reg      <= {3'h0, address_extension_latches, address_top_nibble_reg,
                       address_mid_nibble_reg, address_low_nibble_reg}; // RULE_18 RULE_19
      extra_reg    <= {4'h0, address_extension_latches}; // RULE_18
    end
  end

  assign data_out                  = {high_half_data_reg, low_half_data_reg};
  assign drive                     = drive_reg;
  assign inhibit                   = inhibit_reg;
  assign sense_strobe              = strobe_reg;
  assign busy                      = busy_reg;
  assign parity_error              = perr_reg;
  assign storage_address_register  = addr_reg;
  assign console_hex_address       = hex_reg;
  assign console_extra_display_reg = extra_reg;
endmodule

/* inc/csc_pkg.sv */
/*
  constants, types and timing for the core storage address and read/write control.
  assumes a single 125 mhz clock and the core array's drive/sense logic outside.
*/
// Functional notes
// [RULE_01] byte is two halves: four data plus parity
// [RULE_02] each half carries odd parity
// [RULE_03] read and write half cycles, 1.8 us each
// [RULE_04] read need not be followed by write
// [RULE_05] write drives ones, inhibit bits kept zero
// [RULE_06] read reverses drive, inhibit lines not energized
// [RULE_07] read clears byte, sensed ones set data latches
// [RULE_08] write back same or modified data registers
// [RULE_09] address loaded from nibble regs and extension latch
// [RULE_10] low nibble reaches address through internal bus
// [RULE_11] weights 1-8 pick one of sixteen y blocks
// [RULE_12] weights 16-64 pick one of eight y blocks
// [RULE_13] weights 128-512 pick one of eight x blocks
// [RULE_14] weights 1024-2048 pick one of four x blocks
// [RULE_15] line current direction follows fetch or store
// [RULE_16] four-block x group needs auxiliary latch off
// [RULE_17] 8k: extension bit joins x group two
// [RULE_18] console shows address and extension bit
// [RULE_19] hex address is one digit per register
// [RULE_20] sense strobe only 640 to 840 ns
// [RULE_21] start request only on fetch or store, phase one
// [RULE_22] auxiliary latch set by auxiliary microinstructions
package csc_pkg;

  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned HALF_CYCLE_NS   = 1800;
  localparam int unsigned X_ON_START_NS   = 0;
  localparam int unsigned X_ON_END_NS     = 1100;
  localparam int unsigned Y_ON_START_NS   = 300;
  localparam int unsigned Y_ON_END_NS     = 1100;
  localparam int unsigned INH_END_NS      = 1100;
  localparam int unsigned STROBE_START_NS = 640;
  localparam int unsigned STROBE_END_NS   = 840;

  // least times round up, longest round down
  localparam int unsigned HALF_CYCLE_CYC  = (HALF_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned Y_ON_START_CYC  = (Y_ON_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned DRIVE_END_CYC   = (X_ON_END_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned INH_END_CYC     = (INH_END_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned STROBE_BEG_CYC  = (STROBE_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam int unsigned STROBE_END_CYC  = (STROBE_END_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned X_ON_START_CYC  = (X_ON_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;

  localparam int unsigned TIMER_W         = 8;
  localparam int unsigned ADDR_W          = 13;

  // address field positions inside the storage address register
  localparam int unsigned Y_WR_LSB  = 0;
  localparam int unsigned Y_RD_LSB  = 4;
  localparam int unsigned X_G1_LSB  = 7;
  localparam int unsigned X_G2_LSB  = 10;
  localparam int unsigned EXT_POS   = 12;

  localparam logic [12:0] ADDR_RST = 13'h0000;
  localparam logic [3:0]  NIB_RST  = 4'h0;
  localparam logic [4:0]  HALF_RST = 5'h01;

  // one half byte: parity above four weighted data bits
  typedef struct packed {
    logic       par;
    logic [3:0] data;
  } csc_half_t;

  typedef struct packed {
    csc_half_t hi;
    csc_half_t lo;
  } csc_byte_t;

  typedef struct packed {
    logic [15:0] y_wr_drv;
    logic [7:0]  y_rd_drv;
    logic [7:0]  x_g1;
    logic [7:0]  x_g2;
    logic        x_en;
    logic        y_en;
    logic        dir_store;
  } csc_drive_t;

  typedef enum logic [1:0] {
    CSC_OP_NONE,
    CSC_OP_FETCH,
    CSC_OP_STORE
  } csc_op_t;

endpackage

/* logic/csc_parity.sv */
/*
  odd parity generator and checker for one half byte.
  assumes data from same-clock logic; purely combinational.
*/
`timescale 1ns/10ps
module csc_parity (
  input  wire logic [3:0] data,
  input  wire logic       par_in,
  output logic            par_gen,
  output logic            par_err
);
  import csc_pkg::*;

  assign par_gen = ~(^data);            // RULE_02
  assign par_err = ~(^{par_in, data});  // RULE_02
endmodule

/* logic/csc_decode.sv */
/*
  one-hot decoder for a driver/switch group select.
  assumes a stable address field and a gating enable.
*/
`timescale 1ns/10ps
module csc_decode #(
  parameter int unsigned IN_W = 3
) (
  input  wire logic                 en,
  input  wire logic [IN_W-1:0]      sel,
  output logic      [(1<<IN_W)-1:0] hot
);
  import csc_pkg::*;

  localparam int unsigned OUT_W = 1 << IN_W;

  assign hot = en ? (OUT_W'(1) << sel) : '0;
endmodule

/* tb/csc_core_ctl_sva.sv */
/*
  port checker for the core storage control: timing, selects, inhibit.
  assumes one clock and the bind at the foot of this file.
*/
`timescale 1ns/10ps
module csc_core_ctl_sva
  import csc_pkg::*;
#(
  parameter bit EIGHT_K = 1'b1
) (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       start_fetch,
  input wire logic       start_store,
  input wire logic       aux_access,
  input wire logic       aux_clear,
  input wire logic       addr_load,
  input wire csc_byte_t  data_out,
  input wire csc_drive_t drive,
  input wire logic [9:0] inhibit,
  input wire logic       sense_strobe,
  input wire logic       busy,
  input wire logic [12:0] storage_address_register,
  input wire logic [15:0] console_hex_address
);
  logic [7:0] cnt_reg;
  logic       rd_reg;
  logic       aux_reg;
  wire        go = (start_fetch ^ start_store) && !busy;
  wire [12:0] sar = storage_address_register;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
      rd_reg  <= 1'b0;
      aux_reg <= 1'b0;
    end else begin
      cnt_reg <= busy ? cnt_reg + 8'h01 : 8'h00;
      rd_reg  <= go ? start_fetch : rd_reg;
      aux_reg <= aux_access | (aux_reg & ~aux_clear);
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  busy_len_a: assert property ($fell(busy) |-> cnt_reg == HALF_CYCLE_CYC)
    else $error("half cycle length off");
  start_busy_a: assert property (go |=> busy)
    else $error("start not taken");
  both_refused_a: assert property (start_fetch && start_store && !busy |=> !busy)
    else $error("double start taken");
  strobe_win_a: assert property (sense_strobe |-> busy && rd_reg
    && cnt_reg >= STROBE_BEG_CYC && cnt_reg < STROBE_END_CYC)
    else $error("strobe outside window");
  strobe_hit_a: assert property (go && start_fetch |-> ##[80:110] sense_strobe)
    else $error("read without strobe");
  read_quiet_a: assert property (busy && rd_reg |-> inhibit == 10'h000)
    else $error("inhibit during read");
  write_inh_a: assert property (busy && !rd_reg && cnt_reg == 8'h0a
    |-> inhibit == ~10'(data_out))
    else $error("inhibit not inverse of data");
  drive_dir_a: assert property (drive.x_en |-> drive.dir_store == !rd_reg)
    else $error("drive direction wrong");
  y_sel_a: assert property (drive.y_en |-> drive.y_wr_drv == (16'h0001 << sar[3:0])
    && drive.y_rd_drv == (8'h01 << sar[6:4]))
    else $error("y select wrong");
  x_sel_a: assert property (drive.x_en && !$past(aux_reg) |->
    drive.x_g1 == (8'h01 << sar[9:7]) && drive.x_g2 == (8'h01 << {EIGHT_K & sar[12], sar[11:10]}))
    else $error("x select wrong");
  aux_gate_a: assert property (aux_reg && $past(aux_reg) && $past(aux_reg, 2)
    |-> drive.x_g2 == 8'h00)
    else $error("main drive while aux set");
  sar_load_a: assert property (go |=> sar == {EIGHT_K & console_hex_address[12],
    console_hex_address[11:0]})
    else $error("address not captured");

  cover property (go && start_fetch);
  cover property (go && start_store);
  cover property (aux_reg && go);
endmodule

bind csc_core_ctl csc_core_ctl_sva #(.EIGHT_K(EIGHT_K)) chk (.clk_sys, .nrst, .start_fetch,
  .start_store, .aux_access, .aux_clear, .addr_load, .data_out, .drive, .inhibit,
  .sense_strobe, .busy, .storage_address_register, .console_hex_address);

/* tb/csc_array_model.sv */
/*
  behavioural core array: ten bit planes, destructive read, inhibit write.
  assumes the address seen is the storage address register.
*/
`timescale 1ns/10ps
module csc_array_model
  import csc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire csc_drive_t  drive,
  input  wire logic [9:0]  inhibit,
  input  wire logic [12:0] addr,
  output logic [9:0]       sense_in
);
  logic [9:0] mem [0:8191];
  logic [9:0] rd_reg = 10'h000;
  logic       tog_reg = 1'b0;
  logic       was_reg = 1'b0;
  wire        on_w = drive.x_en && drive.y_en && (drive.x_g2 != 8'h00);

  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem[i] = 10'h000;
    end
  end

  always @(posedge clk_sys) begin
    tog_reg <= ~tog_reg;
    was_reg <= on_w;
    if (on_w && !was_reg && !drive.dir_store) begin
      rd_reg    <= mem[addr];
      mem[addr] <= 10'h000;
    end
    if (on_w && drive.dir_store) begin
      mem[addr] <= mem[addr] | ~inhibit;
    end
  end

  // amps idle low under drive, lines float with no drive at all
  assign sense_in = (on_w && was_reg && !drive.dir_store) ? rd_reg :
                    (drive.x_en ? 10'h000 : {10{tog_reg}});
endmodule

/* tb/tb_csc_core_ctl.sv */
/*
  testbench for the core storage control with the array model.
  assumes the default eight-k build and 125 mhz clock.
*/
`timescale 1ns/10ps
module tb_csc_core_ctl;
  import csc_pkg::*;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic       start_fetch = 1'b0;
  logic       start_store = 1'b0;
  logic       aux_access = 1'b0;
  logic       aux_clear = 1'b0;
  logic       addr_load = 1'b0;
  logic       data_load = 1'b0;
  logic [3:0] top = 4'h0;
  logic [3:0] mid = 4'h0;
  logic [3:0] internal_bus = 4'h0;
  logic       ext = 1'b0;
  csc_byte_t  data_in = 10'h000;
  csc_byte_t  data_out;
  csc_drive_t drive;
  logic [9:0] inhibit;
  logic [9:0] sense_in;
  logic       busy;
  logic       strobe;
  logic       parity_error;
  logic [12:0] sar;
  logic [15:0] hex;
  logic [4:0]  extra;
  int         n_fail = 0;
  int         tests_run = 0;
  int         cyc = 0;

  csc_core_ctl dut (.clk_sys, .nrst, .start_fetch, .start_store, .aux_access, .aux_clear,
    .addr_load, .address_top_nibble_in(top), .address_mid_nibble_in(mid), .internal_bus,
    .address_extension_in(ext), .data_load, .data_in, .sense_in, .data_out, .drive,
    .inhibit, .sense_strobe(strobe), .busy, .parity_error, .storage_address_register(sar),
    .console_hex_address(hex), .console_extra_display_reg(extra));
  csc_array_model arr (.clk_sys, .drive, .inhibit, .addr(sar), .sense_in);

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  function automatic csc_byte_t mk(input logic [7:0] d);
    mk = {~^d[7:4], d[7:4], ~^d[3:0], d[3:0]};
  endfunction

  task automatic setup(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    {ext, top, mid, internal_bus} <= a;
    data_in   <= mk(d);
    addr_load <= 1'b1;
    data_load <= 1'b1;
    @(posedge clk_sys);
    addr_load <= 1'b0;
    data_load <= 1'b0;
  endtask

  task automatic run(input logic f);
    int n;
    int ns;
    @(posedge clk_sys);
    start_fetch <= f;
    start_store <= !f;
    @(posedge clk_sys);
    start_fetch <= 1'b0;
    start_store <= 1'b0;
    n = 0;
    ns = 0;
    @(negedge clk_sys);
    while (busy === 1'b1 && n < 400) begin
      n++;
      if (strobe === 1'b1) begin
        ns++;
      end
      @(negedge clk_sys);
    end
    chk("half cycle", 16'(n), 16'(HALF_CYCLE_CYC));
    chk("strobe length", 16'(ns), f ? 16'(STROBE_END_CYC - STROBE_BEG_CYC) : 16'h0000);
  endtask

  task automatic t_rw(input logic [12:0] a, input logic [7:0] d);
    setup(a, d);
    repeat (2) @(negedge clk_sys);
    chk("hex address", hex, {3'h0, a});
    chk("extra display", 16'(extra[0]), 16'(a[12]));
    run(1'b0);
    setup(a, ~d);
    run(1'b1);
    chk("read data", 16'(data_out), 16'(mk(d)));
    chk("parity ok", 16'(parity_error), 16'h0000);
    run(1'b1);
    chk("destroyed", 16'(data_out), 16'h0000);
    chk("parity bad", 16'(parity_error), 16'h0001);
  endtask

  task automatic t_wb();
    setup(13'h0d2e, 8'h5a);
    run(1'b0);
    run(1'b1);
    run(1'b0);
    run(1'b1);
    chk("write back", 16'(data_out), 16'(mk(8'h5a)));
  endtask

  task automatic t_both();
    @(posedge clk_sys);
    start_fetch <= 1'b1;
    start_store <= 1'b1;
    @(posedge clk_sys);
    start_fetch <= 1'b0;
    start_store <= 1'b0;
    @(negedge clk_sys);
    chk("double start", 16'(busy), 16'h0000);
  endtask

  task automatic t_aux();
    setup(13'h00a5, 8'hc3);
    run(1'b0);
    @(posedge clk_sys);
    aux_access <= 1'b1;
    @(posedge clk_sys);
    aux_access <= 1'b0;
    run(1'b1);
    chk("aux read", 16'(data_out), 16'h0000);
    @(posedge clk_sys);
    aux_clear <= 1'b1;
    @(posedge clk_sys);
    aux_clear <= 1'b0;
    run(1'b1);
    chk("main read", 16'(data_out), 16'(mk(8'hc3)));
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk("reset data", 16'(data_out), 16'h0021);
    t_rw(13'h0000, 8'h00);
    t_rw(13'h1fff, 8'hff);
    t_rw(13'h0a5c, 8'h96);
    t_rw(13'h1001, 8'h3c);
    t_wb();
    t_both();
    t_aux();
    end_of_test();
  end
endmodule
